/* File: verilog/p2s_shift_register.sv */
// Operation
// - eight stages form one chain; last stage driven true and inverted.
// - load_n low copies parallel inputs into all stages, overriding clocks.
// - while load_n stays low, stages keep following parallel inputs.
// - load_n high: rising clock shifts toward last stage, first takes serial_in.
// - effective shift clock is OR of clock_in_a and clock_in_b.
// - either clock input held high freezes contents; inputs behave alike.
// - inhibit rising while other clock low shifts like a clock edge.
// - shifting edge triggered; serial_in only matters at the rising edge.
`timescale 1ns/1ps

// ------------------------------------------------------------
// stream fifo
// ------------------------------------------------------------
module p2s_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} fifo_state_s;

	fifo_state_s cur;
	fifo_state_s next_cur;
	logic do_push;
	logic do_pop;

	always_comb begin
		do_push = in_valid && in_ready;
		do_pop = out_valid && out_ready;
		next_cur = cur;
		if (do_push) begin
			next_cur.mem[cur.wr_ptr] = in_data;
			next_cur.wr_ptr = (cur.wr_ptr == PW'(DEPTH - 1)) ? '0 : cur.wr_ptr + 1'b1;
		end
		if (do_pop) begin
			next_cur.rd_ptr = (cur.rd_ptr == PW'(DEPTH - 1)) ? '0 : cur.rd_ptr + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_cur.count = cur.count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_cur.count = cur.count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// full and empty straight from the count, no lookahead
	assign in_ready = (cur.count != CW'(DEPTH));
	assign out_valid = (cur.count != '0);
	assign out_data = cur.mem[cur.rd_ptr];

endmodule : p2s_fifo

// ------------------------------------------------------------
// shift register
// ------------------------------------------------------------
module p2s_shift_register (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load_n,
	input wire logic clock_in_a,
	input wire logic clock_in_b,
	input wire logic serial_in,
	input wire logic [p2s_pkg::STAGE_COUNT-1:0] parallel_in,
	output logic serial_out,
	output logic serial_out_n,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic [p2s_pkg::FIFO_WIDTH-1:0] stream_data
);
	p2s_pkg::shifter_state_s cur;
	p2s_pkg::shifter_state_s next_cur;
	p2s_pkg::pins_s pins;
	logic clock_or;
	logic clock_rise;
	logic shift_req;
	logic shift_bit;
	logic push_valid;
	logic push_ready;

	// ------------------------------------------------------------
	// shift and load
	// ------------------------------------------------------------
	always_comb begin
		pins = '{
			load_n: load_n,
			clock_in_a: clock_in_a,
			clock_in_b: clock_in_b,
			serial_in: serial_in,
			parallel_in: parallel_in
		};
		next_cur = cur;
		// pins pass two flops; only the second stage feeds logic
		next_cur.meta = pins;
		next_cur.stable = cur.meta;
		clock_or = cur.stable.clock_in_a | cur.stable.clock_in_b;
		next_cur.clock_or_prev = clock_or;
		clock_rise = clock_or && !cur.clock_or_prev;
		shift_req = 1'b0;
		shift_bit = cur.pending_bit;
		push_valid = 1'b0;
		if (!cur.stable.load_n) begin
			// load overrides clocking and drops any held shift
			next_cur.stages = cur.stable.parallel_in;
			next_cur.shift_pending = 1'b0;
		end else begin
			shift_req = clock_rise || cur.shift_pending;
			if (clock_rise) begin
				shift_bit = cur.stable.serial_in;
			end
			if (shift_req) begin
				push_valid = 1'b1;
				if (push_ready) begin
					// toward the last stage, new bit into the first
					next_cur.stages = {cur.stages[p2s_pkg::STAGE_COUNT-2:0], shift_bit};
					next_cur.shift_pending = 1'b0;
				end else begin
					// fifo full: hold the shift and its bit until room
					next_cur.shift_pending = 1'b1;
					next_cur.pending_bit = shift_bit;
				end
			end
		end
	end

	// stages reset here only for a known simulation start
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cur <= p2s_pkg::SHIFTER_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign serial_out = cur.stages[p2s_pkg::STAGE_COUNT-1];
	assign serial_out_n = ~cur.stages[p2s_pkg::STAGE_COUNT-1];

	// each shift pushes the bit that becomes the new last stage
	p2s_fifo #(
		.WIDTH(p2s_pkg::FIFO_WIDTH),
		.DEPTH(p2s_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(cur.stages[p2s_pkg::STAGE_COUNT-2]),
		.out_valid(stream_valid),
		.out_ready(stream_ready),
		.out_data(stream_data)
	);

endmodule : p2s_shift_register

/* File: verilog/p2s_pkg.sv */
package p2s_pkg;

	// ------------------------------------------------------------
	// sizes and reset values
	// ------------------------------------------------------------
	localparam int STAGE_COUNT = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 1;
	localparam logic [STAGE_COUNT-1:0] STAGES_RESET = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic load_n;
		logic clock_in_a;
		logic clock_in_b;
		logic serial_in;
		logic [STAGE_COUNT-1:0] parallel_in;
	} pins_s;

	typedef struct packed {
		pins_s meta;
		pins_s stable;
		logic clock_or_prev;
		logic shift_pending;
		logic pending_bit;
		logic [STAGE_COUNT-1:0] stages;
	} shifter_state_s;

	localparam pins_s PINS_RESET = '{
		load_n: 1'b1,
		clock_in_a: 1'b0,
		clock_in_b: 1'b0,
		serial_in: 1'b0,
		parallel_in: 8'h00
	};

	localparam shifter_state_s SHIFTER_RESET = '{
		meta: PINS_RESET,
		stable: PINS_RESET,
		clock_or_prev: 1'b0,
		shift_pending: 1'b0,
		pending_bit: 1'b0,
		stages: STAGES_RESET
	};

endpackage : p2s_pkg

/* File: sim/p2s_props.sv */
`timescale 1ns/1ps
module p2s_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load_n,
	input wire logic clock_in_a,
	input wire logic clock_in_b,
	input wire logic serial_in,
	input wire logic [p2s_pkg::STAGE_COUNT-1:0] parallel_in,
	input wire logic serial_out,
	input wire logic serial_out_n,
	input wire logic stream_valid,
	input wire logic stream_ready,
	input wire logic [p2s_pkg::FIFO_WIDTH-1:0] stream_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// pins land three edges after sampling, so windows look back 3 to 5
	wire ck = clock_in_a | clock_in_b;
	AST_INV: assert property (serial_out_n != serial_out) else $error("inverse");
	AST_LOAD: assert property (!load_n [*4] |-> serial_out == $past(parallel_in[7], 3))
		else $error("load");
	AST_LOAD_N: assert property (!load_n [*4] |-> serial_out_n != $past(parallel_in[7], 3))
		else $error("load inverse");
	AST_NO_PUSH: assert property (!load_n [*5] |-> !$rose(stream_valid)) else $error("push");
	AST_HOLD: assert property (
		(load_n && stream_ready && $stable(ck)) [*5] |-> $stable(serial_out)) else $error("hold");
	AST_SHIFT: assert property (
		load_n [*4] ##0 ($rose(ck) && !stream_valid) |-> ##3 stream_valid) else $error("shift");
	AST_PUSH: assert property ($rose(stream_valid) |-> stream_data[0] == serial_out)
		else $error("data");
	AST_STALL: assert property (
		stream_valid && !stream_ready |=> stream_valid && $stable(stream_data)) else $error("stall");
endmodule : p2s_props
bind p2s_shift_register p2s_props props (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.load_n(load_n),
	.clock_in_a(clock_in_a),
	.clock_in_b(clock_in_b),
	.serial_in(serial_in),
	.parallel_in(parallel_in),
	.serial_out(serial_out),
	.serial_out_n(serial_out_n),
	.stream_valid(stream_valid),
	.stream_ready(stream_ready),
	.stream_data(stream_data)
);

/* File: sim/p2s_host.sv */
`timescale 1ns/1ps
module p2s_host (
	input wire logic sys_clk,
	output logic load_n,
	output logic clock_in_a,
	output logic clock_in_b,
	output logic serial_in,
	output logic [p2s_pkg::STAGE_COUNT-1:0] parallel_in
);
	initial {load_n, clock_in_a, clock_in_b, serial_in, parallel_in} = 12'h800;
	task automatic drive(input logic [2:0] abs, input int n);
		{clock_in_a, clock_in_b, serial_in} = abs;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : drive
	// a clock pulse inside the load window must not shift
	task automatic load(input logic [7:0] v);
		{load_n, parallel_in} = {1'b0, ~v};
		drive(3'b000, 4);
		parallel_in = v;
		drive(3'b100, 4);
		{load_n, parallel_in} = {1'b1, ~v};
		drive(3'b000, 4);
	endtask : load
	task automatic shift(input logic use_b, input logic b);
		drive({2'b00, b}, 2);
		drive({!use_b, use_b, b}, 2);
		drive({2'b00, !b}, 2);
	endtask : shift
	// b raised only while a is high, so a's later edges are masked
	task automatic inhibit;
		drive(3'b001, 2);
		drive(3'b101, 2);
		drive(3'b110, 2);
		drive(3'b010, 2);
		drive(3'b110, 2);
		drive(3'b100, 2);
		drive(3'b000, 4);
	endtask : inhibit
endmodule : p2s_host

/* File: sim/p2s_shift_register_test.sv */
`timescale 1ns/1ps
module p2s_shift_register_test;
	logic sys_clk = 1'b0, sys_rst = 1'b1, stream_ready = 1'b0;
	logic load_n, clock_in_a, clock_in_b, serial_in, serial_out, serial_out_n, stream_valid;
	logic [p2s_pkg::STAGE_COUNT-1:0] parallel_in, q;
	logic [p2s_pkg::FIFO_WIDTH-1:0] stream_data;
	logic [8:0] w;
	int compares = 0, n_mismatch = 0;
	always #4 sys_clk = ~sys_clk;
	p2s_host host (
		.sys_clk(sys_clk),
		.load_n(load_n),
		.clock_in_a(clock_in_a),
		.clock_in_b(clock_in_b),
		.serial_in(serial_in),
		.parallel_in(parallel_in)
	);
	p2s_shift_register uut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load_n(load_n),
		.clock_in_a(clock_in_a),
		.clock_in_b(clock_in_b),
		.serial_in(serial_in),
		.parallel_in(parallel_in),
		.serial_out(serial_out),
		.serial_out_n(serial_out_n),
		.stream_valid(stream_valid),
		.stream_ready(stream_ready),
		.stream_data(stream_data)
	);
	task automatic chk(input string what, input logic seen, input logic want);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", what, want, seen);
		end
	endtask : chk
	// stalled sink: eight shifts fill the fifo, the ninth waits for room
	task automatic test_fill;
		logic [8:0] pat = 9'h1a5;
		host.load(8'h5a);
		q = 8'h5a;
		chk("serial_out", serial_out, 1'b0);
		chk("serial_out_n", serial_out_n, 1'b1);
		for (int i = 0; i < 9; i++) begin
			host.shift(i[0], pat[i]);
			w[i] = q[6];
			if (i < 8)
				q = {q[6:0], pat[i]};
			chk("serial_out", serial_out, q[7]);
		end
		for (int i = 0; i < 9; i++) begin
			chk("stream_valid", stream_valid, 1'b1);
			chk("stream_data", stream_data[0], w[i]);
			stream_ready = 1'b1;
			host.drive(3'b000, 1);
			stream_ready = 1'b0;
			host.drive(3'b000, 2);
		end
		q = {q[6:0], pat[8]};
		chk("stream_valid", stream_valid, 1'b0);
		chk("serial_out", serial_out, q[7]);
		$display("test_fill done");
	endtask : test_fill
	task automatic test_inhibit;
		stream_ready = 1'b1;
		host.inhibit();
		chk("serial_out", serial_out, q[6]);
		chk("serial_out_n", serial_out_n, !q[6]);
		$display("test_inhibit done");
	endtask : test_inhibit
	task automatic print_verdict;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (10) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		test_fill();
		test_inhibit();
		print_verdict();
	end
endmodule : p2s_shift_register_test
